// >>> logic/bte_pkg.sv
// Constants, register map and types shared by the bridge timeout error reporting block.
// Functional notes
// [R1] Owned request timing out with link up acts as an Unsupported Request completion.
// [R2] Completion timers cover internal and forwarded requests.
// [R3] Completion timeout sets its uncorrectable status bit.
// [R4] Unmasked timeout with free pointer logs header and first-error pointer; the code logs completion timeouts only, not discard expiry.
// [R5] Unmasked timeout: system error on command enable or matched device and root enables.
// [R6] Unmasked timeout interrupts when enabled, root reporting matches, system-error path on.
// [R7] Interrupt sends MSI when enabled, otherwise asserts legacy INTA.
// [R8] Timeout sets fatal or non-fatal detected by its severity.
// [R9] Signaled system error set only when unmasked and command system-error enable set.
// [R10] Each queued delayed transaction has its own discard timer.
// [R11] Discard expiry sets bridge-control and secondary expired status bits.
// [R12] Reverse mode processes correctable, non-fatal and fatal link messages.
// [R13] Non-fatal or fatal messages set received system error; correctable do not.
// [R14] Message drives system error when its class root enable is set.
// [R15] Uncorrectable messages drive system error when command and bridge enables set.
// [R16] Message interrupts when its class root reporting enable is set.
// [R17] Severity bit set means fatal, clear means non-fatal.
package bte_pkg;

  // Bus and storage sizes.
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int HDR_W     = 128;
  localparam int NUM_CPL   = 8;
  localparam int CPL_TAG_W = 3;
  localparam int NUM_DT    = 4;
  localparam int DT_SLOT_W = 2;
  localparam int TMR_W     = 16;

  // Timing: completion timeout is a least time, so the cycle count rounds up.
  localparam int CLK_PERIOD_NS      = 100;
  localparam int CPL_TIMEOUT_NS     = 50000;
  localparam int CPL_TIMEOUT_CYCLES = (CPL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DT_DISCARD_CYCLES  = 32768;

  // Register offsets (byte addresses).
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ERRCFG   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_HDR0     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HDR1     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_HDR2     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_HDR3     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_FEP      = 8'h20;

  // Control register fields.
  localparam int CTRL_W          = 13;
  localparam int C_CMD_SERR      = 0;
  localparam int C_BCTL_SERR     = 1;
  localparam int C_INTX_DIS      = 2;
  localparam int C_MSI_EN        = 3;
  localparam int C_REVERSE       = 4;
  localparam int C_DEV_NF_EN     = 5;
  localparam int C_DEV_FAT_EN    = 6;
  localparam int C_ROOT_SE_COR   = 7;
  localparam int C_ROOT_SE_NF    = 8;
  localparam int C_ROOT_SE_FAT   = 9;
  localparam int C_REC_COR       = 10;
  localparam int C_REC_NF        = 11;
  localparam int C_REC_FAT       = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;

  // Error configuration fields: masks and severities (set means fatal).
  localparam int ERRCFG_W   = 4;
  localparam int E_CTO_MASK = 0;
  localparam int E_CTO_SEV  = 1;
  localparam int E_DTD_MASK = 2;
  localparam int E_DTD_SEV  = 3;
  localparam logic [ERRCFG_W-1:0] ERRCFG_RESET = 4'h0;

  // Sticky status bits, cleared by a read of the status register.
  localparam int STAT_W      = 10;
  localparam int S_CTO       = 0;
  localparam int S_DTD_EXP   = 1;
  localparam int S_DISCARD   = 2;
  localparam int S_FAT_DET   = 3;
  localparam int S_NF_DET    = 4;
  localparam int S_SIG_SERR  = 5;
  localparam int S_RX_SERR   = 6;
  localparam int S_MSG_COR   = 7;
  localparam int S_MSG_NF    = 8;
  localparam int S_MSG_FAT   = 9;
  localparam logic [STAT_W-1:0] STAT_RESET = 10'h000;

  // First-error pointer register layout.
  localparam int FEP_PTR_W = 5;
  localparam int FEP_VALID = 8;
  localparam logic [FEP_PTR_W-1:0] FEP_CTO = 5'h0E;

  // Received error message classes.
  localparam logic [1:0] MSG_COR = 2'h0;
  localparam logic [1:0] MSG_NF  = 2'h1;
  localparam logic [1:0] MSG_FAT = 2'h3;

  // Timer states, Gray coded along idle, run, expired.
  typedef enum logic [1:0] {
    BTE_TMR_IDLE = 2'b00,
    BTE_TMR_RUN  = 2'b01,
    BTE_TMR_EXP  = 2'b11
  } bte_tmr_state_t;

endpackage : bte_pkg

// >>> logic/bte_tmr_if.sv
// Interface joining the reporting logic to one timeout timer.
`timescale 1ns/1ns
interface bte_tmr_if;
  logic arm;
  logic disarm;
  logic ack;
  logic expired;

  // The owner starts, stops and acknowledges; the timer reports expiry.
  modport owner (output arm, output disarm, output ack, input expired);
  modport timer (input arm, input disarm, input ack, output expired);
endinterface : bte_tmr_if

// >>> logic/bte_tmr.sv
// One timeout timer that holds expiry until acknowledged or re-armed.
`timescale 1ns/1ns
module bte_tmr
  import bte_pkg::*;
#(
  parameter logic [TMR_W-1:0] LIMIT = 16'h01F4
)
(
  // Clock and reset.
  input wire logic  mclk,
  input wire logic  reset,
  // Owner side.
  bte_tmr_if.timer  tif
);

  bte_tmr_state_t   state_q;
  bte_tmr_state_t   state_d;
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // Expiry is reached on the last counted cycle.
  wire running = (state_q == BTE_TMR_RUN);
  wire done    = running && (cnt_q == LIMIT - 16'h0001);

  assign cnt_d       = (tif.arm || !running) ? '0 : cnt_q + 16'h0001;
  assign tif.expired = (state_q == BTE_TMR_EXP);

  // Next state: a new arm restarts the count in any state.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BTE_TMR_IDLE: if (tif.arm) state_d = BTE_TMR_RUN;
      BTE_TMR_RUN:
      begin
        if (tif.arm)         state_d = BTE_TMR_RUN;
        else if (tif.disarm) state_d = BTE_TMR_IDLE;
        else if (done)       state_d = BTE_TMR_EXP;
      end
      BTE_TMR_EXP:
      begin
        if (tif.arm)      state_d = BTE_TMR_RUN;
        else if (tif.ack) state_d = BTE_TMR_IDLE;
      end
      default: state_d = BTE_TMR_IDLE;
    endcase
  end

  // State and count registers.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= BTE_TMR_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

endmodule : bte_tmr

// >>> logic/bte_report.sv
// Timeout and error-message reporting block.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module bte_report
  import bte_pkg::*;
#(
  parameter int DT_DISCARD = DT_DISCARD_CYCLES
)
(
  // Clock and reset.
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // Register port.
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [DATA_W-1:0]     reg_rdata,
  // Link requests and completions.
  input  wire logic                  link_up,
  input  wire logic                  npr_issue,
  input  wire logic [CPL_TAG_W-1:0]  npr_tag,
  input  wire logic [HDR_W-1:0]      npr_hdr,
  input  wire logic                  cpl_rx,
  input  wire logic [CPL_TAG_W-1:0]  cpl_tag,
  // Unsupported Request completion out.
  output logic                       ur_cpl_valid,
  output logic      [CPL_TAG_W-1:0]  ur_cpl_tag,
  // Delayed transaction queue.
  input  wire logic                  dt_queue,
  input  wire logic [DT_SLOT_W-1:0]  dt_queue_slot,
  input  wire logic                  dt_done,
  input  wire logic [DT_SLOT_W-1:0]  dt_done_slot,
  output logic                       dt_discard,
  output logic      [DT_SLOT_W-1:0]  dt_discard_slot,
  // Received error messages.
  input  wire logic                  msg_valid,
  input  wire logic [1:0]            msg_class,
  // Open-drain bus error and interrupt pins.
  output logic                       system_error_out_n,
  output logic                       system_error_oe_n,
  output logic                       legacy_irq_a_out_n,
  output logic                       legacy_irq_a_oe_n,
  // MSI write request and block interrupt.
  output logic                       msi_req,
  output logic                       irq
);

  localparam logic [TMR_W-1:0] CPL_LIMIT = TMR_W'(CPL_TIMEOUT_CYCLES);
  localparam logic [TMR_W-1:0] DT_LIMIT  = TMR_W'(DT_DISCARD);

  // Registers.
  logic [CTRL_W-1:0]    ctrl_q;
  logic [ERRCFG_W-1:0]  errcfg_q;
  logic [STAT_W-1:0]    status_q;
  logic [STAT_W-1:0]    status_d;
  logic [STAT_W-1:0]    irq_mask_q;
  logic [HDR_W-1:0]     hdr_log_q;
  logic                 fep_valid_q;
  logic [FEP_PTR_W-1:0] fep_q;
  logic [DATA_W-1:0]    rdata_q;
  logic [HDR_W-1:0]     hdr_mem [NUM_CPL];
  logic                 ur_valid_q;
  logic [CPL_TAG_W-1:0] ur_tag_q;
  logic                 dt_disc_q;
  logic [DT_SLOT_W-1:0] dt_disc_slot_q;
  logic                 serr_q;
  logic                 intx_q;
  logic                 msi_q;
  logic                 irq_q;

  // Timer expiry vectors and the chosen expired slot.
  logic [NUM_CPL-1:0]   cto_exp;
  logic [NUM_DT-1:0]    dt_exp;
  logic                 cto_hit;
  logic [CPL_TAG_W-1:0] cto_idx;
  logic                 dt_hit;
  logic [DT_SLOT_W-1:0] dt_idx;

  // Control field decode.
  wire cmd_serr  = ctrl_q[C_CMD_SERR];
  wire bctl_serr = ctrl_q[C_BCTL_SERR];
  wire intx_dis  = ctrl_q[C_INTX_DIS];
  wire msi_en    = ctrl_q[C_MSI_EN];
  wire reverse   = ctrl_q[C_REVERSE];
  wire cto_mask  = errcfg_q[E_CTO_MASK];
  wire cto_sev   = errcfg_q[E_CTO_SEV];
  wire dtd_mask  = errcfg_q[E_DTD_MASK];
  wire dtd_sev   = errcfg_q[E_DTD_SEV];

  // One completion timer per tag, for internal and forwarded requests alike.
  generate
    for (genvar i = 0; i < NUM_CPL; i++)
    begin : g_cpl
      bte_tmr_if cif ();
      assign cif.arm    = npr_issue && (npr_tag == CPL_TAG_W'(i)); // see [R2]
      assign cif.disarm = cpl_rx && (cpl_tag == CPL_TAG_W'(i));
      assign cif.ack    = cto_hit && (cto_idx == CPL_TAG_W'(i));
      assign cto_exp[i] = cif.expired;
      bte_tmr #(.LIMIT(CPL_LIMIT)) u_tmr (.mclk(mclk), .reset(reset), .tif(cif.timer));
    end
  endgenerate

  // One discard timer per queued delayed transaction.
  generate
    for (genvar j = 0; j < NUM_DT; j++)
    begin : g_dt
      bte_tmr_if dif ();
      assign dif.arm    = dt_queue && (dt_queue_slot == DT_SLOT_W'(j)); // see [R10]
      assign dif.disarm = dt_done && (dt_done_slot == DT_SLOT_W'(j));
      assign dif.ack    = dt_hit && (dt_idx == DT_SLOT_W'(j));
      assign dt_exp[j]  = dif.expired;
      bte_tmr #(.LIMIT(DT_LIMIT)) u_tmr (.mclk(mclk), .reset(reset), .tif(dif.timer));
    end
  endgenerate

  // Lowest expired slot wins; the others keep their expiry for later cycles.
  always_comb
  begin
    cto_hit = 1'b0;
    cto_idx = '0;
    for (int k = NUM_CPL - 1; k >= 0; k--)
    begin
      if (cto_exp[k])
      begin
        cto_hit = 1'b1;
        cto_idx = CPL_TAG_W'(k);
      end
    end
  end

  // Same selection for the discard timers.
  always_comb
  begin
    dt_hit = 1'b0;
    dt_idx = '0;
    for (int k = NUM_DT - 1; k >= 0; k--)
    begin
      if (dt_exp[k])
      begin
        dt_hit = 1'b1;
        dt_idx = DT_SLOT_W'(k);
      end
    end
  end

  // A completion timeout is only reported while the link is up.
  wire cto_ev = cto_hit && link_up; // see [R1]
  wire dtd_ev = dt_hit;             // see [R10]

  // Severity-matched enables: a set severity bit selects the fatal enables.
  wire cto_dev  = cto_sev ? ctrl_q[C_DEV_FAT_EN]  : ctrl_q[C_DEV_NF_EN];  // see [R17]
  wire cto_root = cto_sev ? ctrl_q[C_ROOT_SE_FAT] : ctrl_q[C_ROOT_SE_NF]; // see [R17]
  wire cto_rec  = cto_sev ? ctrl_q[C_REC_FAT]     : ctrl_q[C_REC_NF];     // see [R17]
  wire dtd_dev  = dtd_sev ? ctrl_q[C_DEV_FAT_EN]  : ctrl_q[C_DEV_NF_EN];  // see [R17]
  wire dtd_root = dtd_sev ? ctrl_q[C_ROOT_SE_FAT] : ctrl_q[C_ROOT_SE_NF]; // see [R17]
  wire dtd_rec  = dtd_sev ? ctrl_q[C_REC_FAT]     : ctrl_q[C_REC_NF];     // see [R17]

  // System error and interrupt conditions for the two timeout events.
  wire cto_serr = cto_ev && !cto_mask && (cmd_serr || (cto_dev && cto_root)); // see [R5]
  wire dtd_serr = dtd_ev && !dtd_mask && (dtd_dev && dtd_root || cmd_serr); // see [R5]
  wire cto_int  = cto_ev && !intx_dis && !cto_mask && cto_rec && (cmd_serr || cto_dev); // see [R6]
  wire dtd_int  = dtd_ev && !intx_dis && !dtd_mask && dtd_rec && (cmd_serr || dtd_dev); // see [R6]

  // Received error messages are processed only in reverse-bridge mode.
  wire msg_in   = msg_valid && reverse; // see [R12]
  wire msg_cor  = msg_in && (msg_class == MSG_COR);
  wire msg_nf   = msg_in && (msg_class == MSG_NF);
  wire msg_fat  = msg_in && (msg_class == MSG_FAT);
  wire msg_unc  = msg_nf || msg_fat;
  wire msg_serr = (msg_cor && ctrl_q[C_ROOT_SE_COR]) || (msg_nf && ctrl_q[C_ROOT_SE_NF])
                  || (msg_fat && ctrl_q[C_ROOT_SE_FAT]) // see [R14]
                  || (msg_unc && cmd_serr && bctl_serr); // see [R15]
  wire msg_int  = (msg_cor && ctrl_q[C_REC_COR]) || (msg_nf && ctrl_q[C_REC_NF])
                  || (msg_fat && ctrl_q[C_REC_FAT]); // see [R16]

  wire serr_fire = cto_serr || dtd_serr || msg_serr;
  wire int_fire  = cto_int || dtd_int || msg_int;

  // Status bits raised by this cycle's events.
  wire [STAT_W-1:0] stat_set;
  assign stat_set[S_CTO]      = cto_ev; // see [R3]
  assign stat_set[S_DTD_EXP]  = dtd_ev; // see [R11]
  assign stat_set[S_DISCARD]  = dtd_ev; // see [R11]
  assign stat_set[S_FAT_DET]  = (cto_ev && cto_sev) || (dtd_ev && dtd_sev); // see [R8]
  assign stat_set[S_NF_DET]   = (cto_ev && !cto_sev) || (dtd_ev && !dtd_sev); // see [R8]
  assign stat_set[S_SIG_SERR] = cmd_serr && ((cto_ev && !cto_mask) || (dtd_ev && !dtd_mask)); // see [R9]
  assign stat_set[S_RX_SERR]  = msg_unc; // see [R13]
  assign stat_set[S_MSG_COR]  = msg_cor;
  assign stat_set[S_MSG_NF]   = msg_nf;
  assign stat_set[S_MSG_FAT]  = msg_fat;

  // Header logging when unmasked and the first-error pointer is free.
  wire log_hdr = cto_ev && !cto_mask && !fep_valid_q; // see [R4]

  // Register port decode.
  wire wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_errcfg = reg_wr && (reg_addr == OFS_ERRCFG);
  wire wr_imask  = reg_wr && (reg_addr == OFS_IRQ_MASK);
  wire wr_fep    = reg_wr && (reg_addr == OFS_FEP) && reg_wdata[FEP_VALID];
  wire rd_status = reg_rd && (reg_addr == OFS_STATUS);

  // A read clears the status; an event in the same cycle still sets its bit.
  assign status_d = (rd_status ? STAT_RESET : status_q) | stat_set;

  // Read data selection, unmapped addresses read as zero.
  logic [DATA_W-1:0] rd_mux;
  assign rd_mux =
      (reg_addr == OFS_CTRL)     ? DATA_W'(ctrl_q)     :
      (reg_addr == OFS_ERRCFG)   ? DATA_W'(errcfg_q)   :
      (reg_addr == OFS_STATUS)   ? DATA_W'(status_q)   :
      (reg_addr == OFS_IRQ_MASK) ? DATA_W'(irq_mask_q) :
      (reg_addr == OFS_HDR0)     ? hdr_log_q[31:0]     :
      (reg_addr == OFS_HDR1)     ? hdr_log_q[63:32]    :
      (reg_addr == OFS_HDR2)     ? hdr_log_q[95:64]    :
      (reg_addr == OFS_HDR3)     ? hdr_log_q[127:96]   :
      (reg_addr == OFS_FEP)      ? (DATA_W'(fep_valid_q) << FEP_VALID) | DATA_W'(fep_q) :
                                   '0;

  // Software-written configuration.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_q     <= CTRL_RESET;
      errcfg_q   <= ERRCFG_RESET;
      irq_mask_q <= STAT_RESET;
    end
    else
    begin
      if (wr_ctrl)   ctrl_q     <= reg_wdata[CTRL_W-1:0];
      if (wr_errcfg) errcfg_q   <= reg_wdata[ERRCFG_W-1:0];
      if (wr_imask)  irq_mask_q <= reg_wdata[STAT_W-1:0];
    end
  end

  // Status, read data and block interrupt.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      status_q <= STAT_RESET;
      rdata_q  <= '0;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      rdata_q  <= reg_rd ? rd_mux : '0;
      irq_q    <= |(status_d & irq_mask_q);
    end
  end

  // Request headers kept per tag for logging on timeout.
  always_ff @(posedge mclk)
  begin
    if (npr_issue) hdr_mem[npr_tag] <= npr_hdr;
  end

  // Header log and first-error pointer; logging wins over a clearing write.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      hdr_log_q   <= '0;
      fep_valid_q <= 1'b0;
      fep_q       <= '0;
    end
    else if (log_hdr)
    begin
      hdr_log_q   <= hdr_mem[cto_idx]; // see [R4]
      fep_valid_q <= 1'b1;
      fep_q       <= FEP_CTO;
    end
    else if (wr_fep)
    begin
      fep_valid_q <= 1'b0;
    end
  end

  // Unsupported Request completion and discard notice toward the requesters.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ur_valid_q     <= 1'b0;
      ur_tag_q       <= '0;
      dt_disc_q      <= 1'b0;
      dt_disc_slot_q <= '0;
    end
    else
    begin
      ur_valid_q     <= cto_ev; // see [R1]
      ur_tag_q       <= cto_idx;
      dt_disc_q      <= dtd_ev;
      dt_disc_slot_q <= dt_idx;
    end
  end

  // System error and MSI pulses; INTA stays until status is read.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      serr_q <= 1'b0;
      msi_q  <= 1'b0;
      intx_q <= 1'b0;
    end
    else
    begin
      serr_q <= serr_fire; // see [R5]
      msi_q  <= int_fire && msi_en; // see [R7]
      intx_q <= (int_fire && !msi_en) || (intx_q && !rd_status); // see [R7]
    end
  end

  // Output pins: the error and INTA pins are open drain, driven low only while asserted.
  assign reg_rdata          = rdata_q;
  assign ur_cpl_valid       = ur_valid_q;
  assign ur_cpl_tag         = ur_tag_q;
  assign dt_discard         = dt_disc_q;
  assign dt_discard_slot    = dt_disc_slot_q;
  assign system_error_out_n = ~serr_q;
  assign system_error_oe_n  = ~serr_q;
  assign legacy_irq_a_out_n = ~intx_q;
  assign legacy_irq_a_oe_n  = ~intx_q;
  assign msi_req            = msi_q;
  assign irq                = irq_q;

endmodule : bte_report

// >>> bench/bte_report_props.sv
// Checker of the reporting block ports.
`timescale 1ns/1ns
module bte_report_props
  import bte_pkg::*;
(
  // Clock, reset and register port.
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Requests, completions and messages.
  input wire logic              link_up,
  input wire logic              npr_issue,
  input wire logic [2:0]        npr_tag,
  input wire logic              cpl_rx,
  input wire logic [2:0]        cpl_tag,
  input wire logic              ur_cpl_valid,
  input wire logic [2:0]        ur_cpl_tag,
  input wire logic              msg_valid,
  input wire logic [1:0]        msg_class,
  // Error and interrupt outputs.
  input wire logic              system_error_out_n,
  input wire logic              system_error_oe_n,
  input wire logic              msi_req
);
  logic [CTRL_W-1:0]   ctrl_q;
  logic [ERRCFG_W-1:0] cfg_q;
  logic [NUM_CPL-1:0]  pend_q;

  // Shadow the control words and the requests still owed a completion.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RESET;
      cfg_q <= ERRCFG_RESET;
      pend_q <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == OFS_CTRL)
        ctrl_q <= reg_wdata[CTRL_W-1:0];
      if (reg_wr && reg_addr == OFS_ERRCFG)
        cfg_q <= reg_wdata[ERRCFG_W-1:0];
      if (cpl_rx)
        pend_q[cpl_tag] <= 1'b0;
      if (ur_cpl_valid)
        pend_q[ur_cpl_tag] <= 1'b0;
      if (npr_issue)
        pend_q[npr_tag] <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Read data stand only in the cycle after a read.
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_serr_od;
    system_error_oe_n == system_error_out_n;
  endproperty
  a_serr_od: assert property (p_serr_od) else $error("open drain enable wrong");
  property p_ur_link;
    ur_cpl_valid |-> $past(link_up);
  endproperty
  a_ur_link: assert property (p_ur_link) else $error("timeout with link down");
  property p_ur_owned;
    ur_cpl_valid |-> pend_q[ur_cpl_tag];
  endproperty
  a_ur_owned: assert property (p_ur_owned) else $error("timeout of no request");
  property p_msi_en;
    msi_req |-> ctrl_q[C_MSI_EN];
  endproperty
  a_msi_en: assert property (p_msi_en) else $error("msi while disabled");
  property p_cto_serr;
    ur_cpl_valid && !cfg_q[E_CTO_MASK] && ctrl_q[C_CMD_SERR] |-> !system_error_out_n;
  endproperty
  a_cto_serr: assert property (p_cto_serr) else $error("timeout without serr");
  property p_msg_cor;
    msg_valid && msg_class == MSG_COR && ctrl_q[C_REVERSE] && ctrl_q[C_ROOT_SE_COR] |=> !system_error_out_n;
  endproperty
  a_msg_cor: assert property (p_msg_cor) else $error("cor message without serr");
  property p_msg_fat;
    msg_valid && msg_class == MSG_FAT && ctrl_q[C_REVERSE] && ctrl_q[C_CMD_SERR] && ctrl_q[C_BCTL_SERR]
      |=> !system_error_out_n;
  endproperty
  a_msg_fat: assert property (p_msg_fat) else $error("fatal message without serr");

  // Main scenarios reached.
  c_ur: cover property (ur_cpl_valid);
  c_msi: cover property (msi_req);
  c_msg: cover property (msg_valid ##1 !system_error_out_n);
endmodule : bte_report_props

bind bte_report bte_report_props u_bte_report_props (.*);

// >>> bench/bte_link_model.sv
// Link partner that answers requests after a random delay, or never.
`timescale 1ns/1ns
module bte_link_model
  import bte_pkg::*;
(
  // Clock, reset, requests and the order to stay silent.
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       npr_issue,
  input  wire logic [2:0] npr_tag,
  input  wire logic       drop,
  // Completions sent back.
  output logic            cpl_rx,
  output logic      [2:0] cpl_tag
);
  logic [2:0] tag;

  // One request at a time; the idle tag line shows the inverse of the last tag.
  initial
  begin
    cpl_rx = 1'b0;
    cpl_tag = '0;
    forever
    begin
      @(posedge mclk);
      if (npr_issue && !drop && !reset)
      begin
        tag = npr_tag;
        repeat ($urandom_range(20, 1)) @(posedge mclk);
        cpl_tag <= tag;
        cpl_rx <= 1'b1;
        @(posedge mclk);
        cpl_rx <= 1'b0;
        cpl_tag <= ~tag;
      end
    end
  end
endmodule : bte_link_model

// >>> bench/tb.sv
// Self-checking bench of the timeout error reporting block.
`timescale 1ns/1ns
module tb
  import bte_pkg::*;
;
  // Design and model signals.
  logic              mclk, reset, reg_wr, reg_rd, link_up, npr_issue, cpl_rx, ur_cpl_valid, drop;
  logic              dt_queue, dt_done, dt_discard, msg_valid, msi_req, irq;
  logic              system_error_out_n, system_error_oe_n, legacy_irq_a_out_n, legacy_irq_a_oe_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, v, h;
  logic [2:0]        npr_tag, cpl_tag, ur_cpl_tag;
  logic [HDR_W-1:0]  npr_hdr;
  logic [1:0]        dt_queue_slot, dt_done_slot, dt_discard_slot, msg_class;
  int                n_fail, n_compared, n, k, exp_st;
  logic [ADDR_W-1:0] adr[6] = '{OFS_CTRL, OFS_ERRCFG, OFS_STATUS, OFS_IRQ_MASK, OFS_FEP, 8'h40};
  logic [DATA_W-1:0] m_ctrl[6] = '{32'h0000_0490, 32'h0000_0910, 32'h0000_1210, 32'h0000_0013,
                                   32'h0000_0013, 32'h0000_0480};
  logic [1:0]        m_cls[6] = '{MSG_COR, MSG_NF, MSG_FAT, MSG_COR, MSG_FAT, MSG_COR};
  logic [1:0]        m_exp[6] = '{2'b11, 2'b11, 2'b11, 2'b00, 2'b10, 2'b00};

  bte_report #(.DT_DISCARD(8)) u_bte_report (.*);
  bte_link_model u_bte_link_model (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Check and clear the modelled sticky status.
  task automatic st_chk(input logic [31:0] m);
    rd(OFS_STATUS, v);
    chk(v & m, exp_st & m, "status");
    exp_st = 0;
  endtask : st_chk

  // Count edges until an output pulse shows, giving up after 700.
  task automatic wait_ev(ref logic s);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end while (s !== 1'b1 && n < 700);
  endtask : wait_ev

  task automatic stop_test;
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // Clock of 100 ns period.
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Watchdog against a hang.
  initial
  begin
    repeat (6000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  // Test sequence.
  initial
  begin
    void'($urandom(16));
    {reg_wr, reg_rd, npr_issue, dt_queue, dt_done, msg_valid, drop} = '0;
    {reg_addr, reg_wdata, npr_tag, npr_hdr, dt_queue_slot, dt_done_slot, msg_class} = '0;
    {n_fail, n_compared, exp_st} = '0;
    link_up = 1'b1;
    reset = 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    wr(8'h40, 32'hFFFF_FFFF);
    foreach (adr[i])
    begin
      rd(adr[i], v);
      chk(v, 32'h0000_0000, "reset value");
    end
    h = $urandom();
    wr(OFS_CTRL, h);
    rd(OFS_CTRL, v);
    chk(v, h & 32'h0000_1FFF, "ctrl");
    $display("registers done");
    // Timeout unmasked then masked with fatal severity.
    wr(OFS_CTRL, 32'h0000_0829);
    wr(OFS_IRQ_MASK, 32'h0000_03FF);
    drop = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_ERRCFG, i * 3);
      npr_hdr <= {$urandom(), $urandom(), $urandom(), $urandom()};
      npr_tag <= $urandom_range(7, 0);
      npr_issue <= 1'b1;
      @(posedge mclk);
      npr_issue <= 1'b0;
      if (i == 0)
        h = npr_hdr[31:0];
      wait_ev(ur_cpl_valid);
      chk(n, 1 + CPL_TIMEOUT_CYCLES, "cto delay");
      chk(ur_cpl_tag, npr_tag, "ur tag");
      chk(system_error_out_n, i, "cto serr");
      chk(msi_req, !i, "cto msi");
      chk(legacy_irq_a_out_n, 1'b1, "cto inta");
      exp_st = (1 << S_CTO) | (i ? 1 << S_FAT_DET : (1 << S_NF_DET) | (1 << S_SIG_SERR));
      @(posedge mclk);
      #1 chk(irq, 1'b1, "irq");
      rd(OFS_HDR0, v);
      chk(v, h, "header log");
      rd(OFS_FEP, v);
      chk(v, (1 << FEP_VALID) | FEP_CTO, "pointer");
      st_chk(32'h0000_03FF);
    end
    repeat (2) @(posedge mclk);
    #1 chk(irq, 1'b0, "irq clear");
    // An answered request never times out.
    drop = 1'b0;
    npr_issue <= 1'b1;
    @(posedge mclk);
    npr_issue <= 1'b0;
    wait_ev(ur_cpl_valid);
    chk(n, 700, "answered");
    $display("timeouts done");
    // Discard timer, fatal severity against nonfatal root reporting.
    wr(OFS_CTRL, 32'h0000_0801);
    wr(OFS_ERRCFG, 32'h0000_0008);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    dt_queue_slot <= $urandom_range(3, 0);
    dt_queue <= 1'b1;
    @(posedge mclk);
    dt_queue <= 1'b0;
    wait_ev(dt_discard);
    chk(n, 9, "discard delay");
    chk(dt_discard_slot, dt_queue_slot, "discard slot");
    chk(system_error_out_n, 1'b0, "dt serr");
    chk(legacy_irq_a_out_n, 1'b1, "dt inta");
    exp_st = (1 << S_DTD_EXP) | (1 << S_DISCARD) | (1 << S_FAT_DET) | (1 << S_SIG_SERR);
    @(posedge mclk);
    #1 chk(irq, 1'b0, "irq masked");
    st_chk(32'h0000_03FF);
    $display("discard done");
    // Received error messages of every class.
    wr(OFS_IRQ_MASK, 32'h0000_03FF);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CTRL, m_ctrl[i]);
      msg_class <= m_cls[i];
      msg_valid <= 1'b1;
      @(posedge mclk);
      msg_valid <= 1'b0;
      #1 chk(system_error_out_n, !m_exp[i][1], "msg serr");
      chk(legacy_irq_a_out_n, !m_exp[i][0], "msg inta");
      chk(legacy_irq_a_oe_n, !m_exp[i][0], "inta oe");
      k = (m_cls[i] == MSG_FAT) ? 2 : m_cls[i];
      exp_st = m_ctrl[i][C_REVERSE] ? (1 << (S_MSG_COR + k)) | ((k != 0) << S_RX_SERR) : 0;
      st_chk(32'h0000_03DF);
      repeat (2) @(posedge mclk);
      #1 chk(legacy_irq_a_out_n, 1'b1, "inta clear");
    end
    $display("messages done");
    stop_test();
  end
endmodule : tb
